// ---- logic/dual_byte_gpio_ports.sv ----
// two 8-bit general purpose ports with peripheral overrides and slave mode
//
// Contract
// [RULE_01] Each port is eight pins wide and each pin can be an input or an output.
// [RULE_02] A third-port direction bit of one turns the pin driver off so the pin is an input.
// [RULE_03] A third-port direction bit of zero drives the pin with its output latch bit.
// [RULE_04] Fourth-port direction bits work the same way per pin.
// [RULE_05] Each output latch is its own register and reads back the latch, not the pins.
// [RULE_06] With the capture/compare routing bit at one, third-port pin 1 serves the second capture/compare unit.
// [RULE_07] An enabled peripheral may override a pin direction, forcing it to output or to input.
// [RULE_08] Reading the third-port direction register returns the stored bits despite overrides.
// [RULE_09] After power-on reset every pin is an input and every direction bit is one.
// [RULE_10] Third-port pins 0 and 1 serve the secondary timer oscillator output or clock and its input.
// [RULE_11] Third-port pins 3, 4 and 5 serve the serial port clock, data in and data out.
// [RULE_12] Third-port pins 6 and 7 serve the USART transmit or clock and receive or data.
// [RULE_13] Setting the slave mode bit of the fifth-port control register turns the fourth port into a parallel slave port.
// [RULE_14] In slave mode fourth-port pin n carries parallel data bit n; the code lets an enabled pwm override on pins 5 to 7 win over slave mode.
// [RULE_15] Fourth-port pins 5, 6 and 7 also serve as enhanced pwm outputs b, c and d.
// [RULE_16] Dual or quad output pwm disables slave mode on the fourth port.
// [RULE_17] Reading a pin-value register returns the sampled pin levels.
`timescale 1ns/1ps
module dual_byte_gpio_ports
  import gpio_pkg::*;
(
  input  wire  logic           mclk,
  input  wire  logic           rst_n,
  input  wire  regReq_s        req,
  output       byte_t          rdData,
  input  wire  byte_t          pcIn,
  output       byte_t          pcOut,
  output       byte_t          pcOe,
  input  wire  byte_t          pdIn,
  output       byte_t          pdOut,
  output       byte_t          pdOe,
  input  wire  logic           capcompRouting,
  input  wire  pinOvr_s [1:0]  tmrOvr,
  input  wire  pinOvr_s        ccp2Ovr,
  input  wire  pinOvr_s        ccp1Ovr,
  input  wire  pinOvr_s [2:0]  sspOvr,
  input  wire  pinOvr_s [1:0]  usartOvr,
  input  wire  pinOvr_s [2:0]  pwmOvr,
  input  wire  logic           slaveInFull,
  input  wire  logic           slaveOutFull,
  input  wire  logic           slaveOverflow,
  input  wire  logic           slaveDrive,
  input  wire  byte_t          slaveData,
  output       byte_t          pcPin,
  output       byte_t          pdPin,
  output       logic           ccp2InC,
  output       logic           slaveActive,
  output       logic [2:0]     peDir,
  output       byte_t          pwmCtl
);

  byte_t   pcLat_ff, nxt_pcLat, pcDir_ff, nxt_pcDir;
  byte_t   pdLat_ff, nxt_pdLat, pdDir_ff, nxt_pdDir;
  byte_t   eCtl_ff, nxt_eCtl, pwmCtl_ff, nxt_pwmCtl;
  byte_t   rdData_ff, nxt_rdData;
  byte_t   pcOut_ff, nxt_pcOut, pcOe_ff, nxt_pcOe;
  byte_t   pdOut_ff, nxt_pdOut, pdOe_ff, nxt_pdOe;
  logic    slaveActive_ff, nxt_slaveActive;
  logic    ccp2In_ff, nxt_ccp2In;
  byte_t   cS1_ff, cS2_ff, cS3_ff, cPin_ff, nxt_cPin;
  byte_t   dS1_ff, dS2_ff, dS3_ff, dPin_ff, nxt_dPin;
  pinOvr_s cOvr [PW];
  byte_t   cOvrEn, dOvrEn;
  logic    pwmMulti;
  logic    slaveOn;
  byte_t   eRead;

  // per-pin peripheral map of the third port
  always_comb begin
    cOvr[PIN_TMR_OSO] = tmrOvr[0];                          // RULE_10
    cOvr[PIN_TMR_OSI] = tmrOvr[1];                          // RULE_10
    if (capcompRouting && ccp2Ovr.en) begin
      cOvr[PIN_SECOND_CAPTURE_COMPARE_UNIT] = ccp2Ovr;                             // RULE_06
    end
    cOvr[PIN_CCP1]    = ccp1Ovr;
    cOvr[PIN_SSP_CLK] = sspOvr[0];                          // RULE_11
    cOvr[PIN_SSP_DI]  = sspOvr[1];                          // RULE_11
    cOvr[PIN_SSP_DO]  = sspOvr[2];                          // RULE_11
    cOvr[PIN_USA_TX]  = usartOvr[0];                        // RULE_12
    cOvr[PIN_USA_RX]  = usartOvr[1];                        // RULE_12
    for (int i = 0; i < PW; i++) begin
      cOvrEn[i] = cOvr[i].en;
    end
  end

  // slave mode only while pwm is not in a multi-output mode
  always_comb begin
    pwmMulti = (pwmCtl_ff[PWM_OUT_HI:PWM_OUT_LO] != PWM_SINGLE)
            && (pwmCtl_ff[PWM_SEL_HI:PWM_SEL_LO] == PWM_SEL_PWM);
    slaveOn = eCtl_ff[E_PARALLEL_SLAVE_MODE_SELECT] && !pwmMulti;              // RULE_13 RULE_16
    dOvrEn = ZERO_BYTE;
    for (int i = 0; i < 3; i++) begin
      dOvrEn[PIN_PWM_B + i] = pwmOvr[i].en;
    end
  end

  // pin drivers: peripheral override first, then slave mode on the fourth port, else direction and latch
  always_comb begin
    for (int i = 0; i < PW; i++) begin                      // RULE_01
      if (cOvr[i].en) begin
        nxt_pcOe[i]  = cOvr[i].oe;                          // RULE_07
        nxt_pcOut[i] = cOvr[i].out;
      end else begin
        nxt_pcOe[i]  = !pcDir_ff[i];                        // RULE_02
        nxt_pcOut[i] = pcLat_ff[i];                         // RULE_03
      end
      if (dOvrEn[i]) begin
        nxt_pdOe[i]  = pwmOvr[i - PIN_PWM_B].oe;            // RULE_15
        nxt_pdOut[i] = pwmOvr[i - PIN_PWM_B].out;
      end else if (slaveOn) begin
        nxt_pdOe[i]  = slaveDrive;                          // RULE_14
        nxt_pdOut[i] = slaveData[i];
      end else begin
        nxt_pdOe[i]  = !pdDir_ff[i];                        // RULE_04
        nxt_pdOut[i] = pdLat_ff[i];
      end
    end
    nxt_slaveActive = slaveOn;
    nxt_ccp2In = capcompRouting & cPin_ff[PIN_SECOND_CAPTURE_COMPARE_UNIT];
  end

  // a level change counts once stages two and three agree
  always_comb begin
    nxt_cPin = (cS2_ff & cS3_ff) | (cPin_ff & (cS2_ff ^ cS3_ff));  // RULE_17
    nxt_dPin = (dS2_ff & dS3_ff) | (dPin_ff & (dS2_ff ^ dS3_ff));
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cS1_ff  <= ZERO_BYTE;
      cS2_ff  <= ZERO_BYTE;
      cS3_ff  <= ZERO_BYTE;
      cPin_ff <= ZERO_BYTE;
      dS1_ff  <= ZERO_BYTE;
      dS2_ff  <= ZERO_BYTE;
      dS3_ff  <= ZERO_BYTE;
      dPin_ff <= ZERO_BYTE;
    end else begin
      cS1_ff  <= pcIn;
      cS2_ff  <= cS1_ff;
      cS3_ff  <= cS2_ff;
      cPin_ff <= nxt_cPin;
      dS1_ff  <= pdIn;
      dS2_ff  <= dS1_ff;
      dS3_ff  <= dS2_ff;
      dPin_ff <= nxt_dPin;
    end
  end

  // register writes; a write to the pin-value register lands in the latch
  always_comb begin
    nxt_pcLat  = pcLat_ff;
    nxt_pcDir  = pcDir_ff;
    nxt_pdLat  = pdLat_ff;
    nxt_pdDir  = pdDir_ff;
    nxt_eCtl   = eCtl_ff;
    nxt_pwmCtl = pwmCtl_ff;
    if (req.wr) begin
      case (req.addr)
        REG_C_PIN, REG_C_LAT: nxt_pcLat = req.wdata;       // RULE_05
        REG_C_DIR:            nxt_pcDir = req.wdata;
        REG_D_PIN, REG_D_LAT: nxt_pdLat = req.wdata;       // RULE_05
        REG_D_DIR:            nxt_pdDir = req.wdata;
        REG_E_CTL:            nxt_eCtl  = (eCtl_ff & ~E_WR_MASK) | (req.wdata & E_WR_MASK);
        REG_PWM_CTL:          nxt_pwmCtl = req.wdata;
        default:              nxt_pwmCtl = pwmCtl_ff;
      endcase
    end
    // overflow set beats a software clear in the same cycle
    if (slaveOverflow) begin
      nxt_eCtl[E_IBOV] = 1'b1;
    end
    nxt_eCtl = nxt_eCtl & E_ST_MASK;
  end

  // buffer status bits belong to the slave handshake and are only mirrored
  always_comb begin
    eRead = eCtl_ff;
    eRead[E_IBF] = slaveInFull;
    eRead[E_OBF] = slaveOutFull;
    nxt_rdData = ZERO_BYTE;
    if (req.rd) begin
      case (req.addr)
        REG_C_PIN:   nxt_rdData = cPin_ff;                  // RULE_17
        REG_C_LAT:   nxt_rdData = pcLat_ff;                 // RULE_05
        REG_C_DIR:   nxt_rdData = pcDir_ff;                 // RULE_08
        REG_D_PIN:   nxt_rdData = dPin_ff;                  // RULE_17
        REG_D_LAT:   nxt_rdData = pdLat_ff;                 // RULE_05
        REG_D_DIR:   nxt_rdData = pdDir_ff;
        REG_E_CTL:   nxt_rdData = eRead;
        REG_PWM_CTL: nxt_rdData = pwmCtl_ff;
        default:     nxt_rdData = ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pcLat_ff       <= LAT_RST;
      pcDir_ff       <= DIR_RST;                            // RULE_09
      pdLat_ff       <= LAT_RST;
      pdDir_ff       <= DIR_RST;                            // RULE_09
      eCtl_ff        <= E_CTL_RST;
      pwmCtl_ff      <= PWM_RST;
      rdData_ff      <= ZERO_BYTE;
      pcOut_ff       <= LAT_RST;
      pcOe_ff        <= ZERO_BYTE;
      pdOut_ff       <= LAT_RST;
      pdOe_ff        <= ZERO_BYTE;
      slaveActive_ff <= 1'b0;
      ccp2In_ff      <= 1'b0;
    end else begin
      pcLat_ff       <= nxt_pcLat;
      pcDir_ff       <= nxt_pcDir;
      pdLat_ff       <= nxt_pdLat;
      pdDir_ff       <= nxt_pdDir;
      eCtl_ff        <= nxt_eCtl;
      pwmCtl_ff      <= nxt_pwmCtl;
      rdData_ff      <= nxt_rdData;
      pcOut_ff       <= nxt_pcOut;
      pcOe_ff        <= nxt_pcOe;
      pdOut_ff       <= nxt_pdOut;
      pdOe_ff        <= nxt_pdOe;
      slaveActive_ff <= nxt_slaveActive;
      ccp2In_ff      <= nxt_ccp2In;
    end
  end

  assign rdData      = rdData_ff;
  assign pcOut       = pcOut_ff;
  assign pcOe        = pcOe_ff;
  assign pdOut       = pdOut_ff;
  assign pdOe        = pdOe_ff;
  assign pcPin       = cPin_ff;
  assign pdPin       = dPin_ff;
  assign ccp2InC     = ccp2In_ff;
  assign slaveActive = slaveActive_ff;
  assign peDir       = eCtl_ff[2:0];
  assign pwmCtl      = pwmCtl_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_cDirWr;
    req.wr && req.addr == REG_C_DIR && cOvrEn == ZERO_BYTE ##1 cOvrEn == ZERO_BYTE;
  endsequence

  sequence s_cLatWr;
    req.wr && req.addr == REG_C_LAT && pcDir_ff == ZERO_BYTE && cOvrEn == ZERO_BYTE
      ##1 pcDir_ff == ZERO_BYTE && cOvrEn == ZERO_BYTE;
  endsequence

  sequence s_dDirWr;
    req.wr && req.addr == REG_D_DIR && !slaveOn && dOvrEn == ZERO_BYTE
      ##1 !slaveOn && dOvrEn == ZERO_BYTE;
  endsequence

  a_c_dir_hiz: assert property (s_cDirWr |=> pcOe_ff == ~$past(req.wdata, 2))  // RULE_02
    else $error("third port enables do not follow direction write");
  a_c_lat_drive: assert property (s_cLatWr |=> pcOut_ff == $past(req.wdata, 2)) // RULE_03
    else $error("third port pins do not carry latch value");
  a_d_dir_hiz: assert property (s_dDirWr |=> pdOe_ff == ~$past(req.wdata, 2))   // RULE_04
    else $error("fourth port enables do not follow direction write");
  a_lat_readback: assert property (req.wr && req.addr == REG_D_LAT ##1 req.rd && req.addr == REG_D_LAT // RULE_05
    |=> rdData == $past(req.wdata, 2))
    else $error("latch read does not return written value");
  a_second_capture_compare_unit_route: assert property (capcompRouting && ccp2Ovr.en && ccp2Ovr.oe // RULE_06
    |=> pcOe_ff[PIN_SECOND_CAPTURE_COMPARE_UNIT] && pcOut_ff[PIN_SECOND_CAPTURE_COMPARE_UNIT] == $past(ccp2Ovr.out))
    else $error("second capture unit does not own pin 1");
  a_ovr_force: assert property (usartOvr[0].en |=> pcOe_ff[PIN_USA_TX] == $past(usartOvr[0].oe)) // RULE_07
    else $error("usart override ignored");
  a_dir_readback: assert property (req.wr && req.addr == REG_C_DIR ##1 req.rd && req.addr == REG_C_DIR // RULE_08
    |=> rdData == $past(req.wdata, 2))
    else $error("direction read does not return stored bits");
  a_reset_inputs: assert property ($rose(rst_n) |-> pcOe_ff == ZERO_BYTE && pdOe_ff == ZERO_BYTE // RULE_09
    && pcDir_ff == DIR_RST && pdDir_ff == DIR_RST)
    else $error("pins not inputs after reset");
  a_slave_enter: assert property (eCtl_ff[E_PARALLEL_SLAVE_MODE_SELECT] && !pwmMulti |=> slaveActive) // RULE_13
    else $error("slave mode not entered");
  a_slave_data: assert property (slaveOn && slaveDrive && dOvrEn == ZERO_BYTE // RULE_14
    |=> pdOe == DIR_RST && pdOut == $past(slaveData))
    else $error("slave data not on fourth port");
  a_pwm_pins: assert property (pwmOvr[2].en |=> pdOe_ff[PIN_PWM_B + 2] == $past(pwmOvr[2].oe)) // RULE_15
    else $error("pwm output d not on pin 7");
  a_pwm_gates_slave: assert property (pwmMulti |=> !slaveActive) // RULE_16
    else $error("slave mode active during multi-output pwm");
  a_pin_sample: assert property ((pcIn == $past(pcIn))[*4] |=> pcPin == $past(pcIn)) // RULE_17
    else $error("sampled pin value lags a stable input");

  // read path: each index returns its own state one cycle after the strobe
  a_c_pin_read: assert property (req.rd && req.addr == REG_C_PIN // RULE_17
    |=> rdData == $past(cPin_ff))
    else $error("third port pin read does not return filtered levels");

  a_d_pin_read: assert property (req.rd && req.addr == REG_D_PIN // RULE_17
    |=> rdData == $past(dPin_ff))
    else $error("fourth port pin read does not return filtered levels");

  a_c_lat_read: assert property (req.rd && req.addr == REG_C_LAT // RULE_05
    |=> rdData == $past(pcLat_ff))
    else $error("third port latch read does not return latch");

  a_d_lat_read: assert property (req.rd && req.addr == REG_D_LAT // RULE_05
    |=> rdData == $past(pdLat_ff))
    else $error("fourth port latch read does not return latch");

  a_c_dir_read: assert property (req.rd && req.addr == REG_C_DIR // RULE_08
    |=> rdData == $past(pcDir_ff))
    else $error("third port direction read does not return stored bits");

  a_d_dir_read: assert property (req.rd && req.addr == REG_D_DIR // RULE_04
    |=> rdData == $past(pdDir_ff))
    else $error("fourth port direction read does not return stored bits");

  // read data only stands in the cycle after a strobe
  a_rd_idle: assert property (!req.rd // RULE_05
    |=> rdData == ZERO_BYTE)
    else $error("read data not cleared without a read strobe");

  // pin-value writes land in the latch, so software can treat both alike
  a_c_pinwr_lat: assert property (req.wr && req.addr == REG_C_PIN // RULE_05
    |=> pcLat_ff == $past(req.wdata))
    else $error("third port pin write missed the latch");

  a_d_pinwr_lat: assert property (req.wr && req.addr == REG_D_PIN // RULE_05
    |=> pdLat_ff == $past(req.wdata))
    else $error("fourth port pin write missed the latch");

  // without overrides or slave mode the pins follow direction and latch alone
  a_c_plain_pins: assert property (cOvrEn == ZERO_BYTE // RULE_02
    |=> pcOe_ff == ~$past(pcDir_ff) && pcOut_ff == $past(pcLat_ff))
    else $error("third port pins do not follow direction and latch");

  a_d_plain_pins: assert property (dOvrEn == ZERO_BYTE && !slaveOn // RULE_04
    |=> pdOe_ff == ~$past(pdDir_ff) && pdOut_ff == $past(pdLat_ff))
    else $error("fourth port pins do not follow direction and latch");

  // peripheral pin map
  a_tmr_out_pin: assert property (tmrOvr[0].en // RULE_10
    |=> pcOe_ff[PIN_TMR_OSO] == $past(tmrOvr[0].oe) && pcOut_ff[PIN_TMR_OSO] == $past(tmrOvr[0].out))
    else $error("timer oscillator output not on pin 0");

  a_tmr_in_pin: assert property (tmrOvr[1].en && !(capcompRouting && ccp2Ovr.en) // RULE_10
    |=> pcOe_ff[PIN_TMR_OSI] == $past(tmrOvr[1].oe))
    else $error("timer oscillator input not on pin 1");

  a_ssp_clk_pin: assert property (sspOvr[0].en // RULE_11
    |=> pcOe_ff[PIN_SSP_CLK] == $past(sspOvr[0].oe) && pcOut_ff[PIN_SSP_CLK] == $past(sspOvr[0].out))
    else $error("serial clock not on pin 3");

  a_ssp_do_pin: assert property (sspOvr[2].en // RULE_11
    |=> pcOe_ff[PIN_SSP_DO] == $past(sspOvr[2].oe) && pcOut_ff[PIN_SSP_DO] == $past(sspOvr[2].out))
    else $error("serial data out not on pin 5");

  a_usart_rx_pin: assert property (usartOvr[1].en // RULE_12
    |=> pcOe_ff[PIN_USA_RX] == $past(usartOvr[1].oe) && pcOut_ff[PIN_USA_RX] == $past(usartOvr[1].out))
    else $error("usart receive not on pin 7");

  a_pwm_b_pin: assert property (pwmOvr[0].en // RULE_15
    |=> pdOe_ff[PIN_PWM_B] == $past(pwmOvr[0].oe) && pdOut_ff[PIN_PWM_B] == $past(pwmOvr[0].out))
    else $error("pwm output b not on pin 5");

  a_second_capture_compare_unit_input: assert property (1'b1 // RULE_06
    |=> ccp2InC == $past(capcompRouting && cPin_ff[PIN_SECOND_CAPTURE_COMPARE_UNIT]))
    else $error("capture input does not follow routed pin");

  // control status: overflow is sticky, buffer flags are never stored
  a_ovf_sticky: assert property (slaveOverflow // RULE_13
    |=> eCtl_ff[E_IBOV])
    else $error("overflow event not recorded");

  a_e_stored_bits: assert property ((eCtl_ff & ~E_ST_MASK) == ZERO_BYTE) // RULE_13
    else $error("buffer status bits stored in control register");

endmodule : dual_byte_gpio_ports

// ---- logic/gpio_pkg.sv ----
// constants, types and register map of the dual byte gpio ports
package gpio_pkg;
  localparam int PW = 8;
  localparam int AW = 3;
  typedef logic [AW-1:0] addr_t;
  typedef logic [PW-1:0] byte_t;

  // register indices on the plain register port
  localparam addr_t REG_C_PIN   = 3'h0;
  localparam addr_t REG_C_LAT   = 3'h1;
  localparam addr_t REG_C_DIR   = 3'h2;
  localparam addr_t REG_D_PIN   = 3'h3;
  localparam addr_t REG_D_LAT   = 3'h4;
  localparam addr_t REG_D_DIR   = 3'h5;
  localparam addr_t REG_E_CTL   = 3'h6;
  localparam addr_t REG_PWM_CTL = 3'h7;

  // reset values
  localparam byte_t DIR_RST   = 8'hFF;
  localparam byte_t LAT_RST   = 8'h00;
  localparam byte_t E_CTL_RST = 8'h07;
  localparam byte_t PWM_RST   = 8'h00;
  localparam byte_t ZERO_BYTE = 8'h00;

  // fifth port direction and slave control fields
  localparam int    E_IBF     = 7;
  localparam int    E_OBF     = 6;
  localparam int    E_IBOV    = 5;
  localparam int    E_PARALLEL_SLAVE_MODE_SELECT = 4;
  localparam byte_t E_WR_MASK = 8'h37;
  localparam byte_t E_ST_MASK = 8'h3F;

  // enhanced pwm control fields
  localparam int         PWM_OUT_HI = 7;
  localparam int         PWM_OUT_LO = 6;
  localparam int         PWM_SEL_HI = 3;
  localparam int         PWM_SEL_LO = 2;
  localparam logic [1:0] PWM_SINGLE = 2'h0;
  localparam logic [1:0] PWM_SEL_PWM = 2'h3;

  // pin positions of shared functions
  localparam int PIN_TMR_OSO = 0;
  localparam int PIN_TMR_OSI = 1;
  localparam int PIN_SECOND_CAPTURE_COMPARE_UNIT    = 1;
  localparam int PIN_CCP1    = 2;
  localparam int PIN_SSP_CLK = 3;
  localparam int PIN_SSP_DI  = 4;
  localparam int PIN_SSP_DO  = 5;
  localparam int PIN_USA_TX  = 6;
  localparam int PIN_USA_RX  = 7;
  localparam int PIN_PWM_B   = 5;

  typedef struct packed {
    logic en;
    logic oe;
    logic out;
  } pinOvr_s;

  typedef struct packed {
    logic  wr;
    logic  rd;
    addr_t addr;
    byte_t wdata;
  } regReq_s;
endpackage : gpio_pkg

// ---- sim/board_pins.sv ----
// board side of both ports: pads resolve to driven level or board pull level
`timescale 1ns/1ps
module board_pins
  import gpio_pkg::*;
(
  input  wire logic  [PW-1:0] pcOut,
  input  wire logic  [PW-1:0] pcOe,
  input  wire logic  [PW-1:0] pdOut,
  input  wire logic  [PW-1:0] pdOe,
  input  wire logic  [PW-1:0] pullC,
  input  wire logic  [PW-1:0] pullD,
  output      byte_t          pcIn,
  output      byte_t          pdIn
);
  // an undriven pad settles to the board pull, never to the last driven value
  always_comb begin
    for (int i = 0; i < PW; i++) begin
      pcIn[i] = pcOe[i] ? pcOut[i] : pullC[i];
      pdIn[i] = pdOe[i] ? pdOut[i] : pullD[i];
    end
  end
endmodule : board_pins

// ---- sim/test_dual_byte_gpio_ports.sv ----
// self-checking bench for the dual byte gpio ports
`timescale 1ns/1ps
module test_dual_byte_gpio_ports;
  import gpio_pkg::*;
  logic    mclk = 1'b0;
  logic    rst_n = 1'b0;
  regReq_s req = '0;
  byte_t   rdData, pcIn, pcOut, pcOe, pdIn, pdOut, pdOe, pcPin, pdPin, pwmCtl, pullC, pullD, slaveData, rv;
  logic    capcompRouting, slaveInFull, slaveOutFull, slaveOverflow, slaveDrive, ccp2InC, slaveActive;
  logic [2:0] peDir;
  pinOvr_s ovr [0:11];
  int      err_total = 0;
  int      check_count = 0;
  int      cycles = 0;

  initial begin
    capcompRouting = 1'b0;
    slaveInFull    = 1'b0;
    slaveOutFull   = 1'b0;
    slaveOverflow  = 1'b0;
    slaveDrive     = 1'b0;
    slaveData      = 8'h00;
    pullC          = 8'h00;
    pullD          = 8'h00;
    for (int i = 0; i < 12; i++) ovr[i] = '0;
  end

  always #5 mclk = ~mclk;

  dual_byte_gpio_ports dut (
    .mclk(mclk), .rst_n(rst_n), .req(req), .rdData(rdData),
    .pcIn(pcIn), .pcOut(pcOut), .pcOe(pcOe), .pdIn(pdIn), .pdOut(pdOut), .pdOe(pdOe),
    .capcompRouting(capcompRouting), .tmrOvr({ovr[1], ovr[0]}), .ccp2Ovr(ovr[8]), .ccp1Ovr(ovr[2]),
    .sspOvr({ovr[5], ovr[4], ovr[3]}), .usartOvr({ovr[7], ovr[6]}), .pwmOvr({ovr[11], ovr[10], ovr[9]}),
    .slaveInFull(slaveInFull), .slaveOutFull(slaveOutFull), .slaveOverflow(slaveOverflow),
    .slaveDrive(slaveDrive), .slaveData(slaveData), .pcPin(pcPin), .pdPin(pdPin),
    .ccp2InC(ccp2InC), .slaveActive(slaveActive), .peDir(peDir), .pwmCtl(pwmCtl)
  );

  board_pins board (
    .pcOut(pcOut), .pcOe(pcOe), .pdOut(pdOut), .pdOe(pdOe),
    .pullC(pullC), .pullD(pullD), .pcIn(pcIn), .pdIn(pdIn)
  );

  task automatic stop_test();
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(string what, byte_t exp, byte_t got);
    check_count++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk

  task automatic regWrite(addr_t a, byte_t d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask : regWrite

  // read data is only valid in the cycle after the strobe
  task automatic regRead(addr_t a, output byte_t d);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 d = rdData;
  endtask : regRead

  task automatic readChk(string what, addr_t a, byte_t exp);
    byte_t d;
    regRead(a, d);
    chk(what, exp, d);
  endtask : readChk

  // covers the synchronizer path from pad to pin register
  task automatic settle();
    repeat (6) @(posedge mclk);
    #1;
  endtask : settle

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      stop_test();
    end
  end

  initial begin
    int pin;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    readChk("c_dir_rst", REG_C_DIR, DIR_RST);
    readChk("d_dir_rst", REG_D_DIR, DIR_RST);
    readChk("e_ctl_rst", REG_E_CTL, E_CTL_RST);
    readChk("pwm_rst", REG_PWM_CTL, PWM_RST);
    chk("pc_oe_rst", 8'h00, pcOe);
    chk("pd_oe_rst", 8'h00, pdOe);
    // third port: mixed directions, latch differs from pads
    pullC <= 8'h3C;
    regWrite(REG_C_LAT, 8'hA5);
    regWrite(REG_C_DIR, 8'hF0);
    settle();
    chk("pc_oe", 8'h0F, pcOe);
    chk("pc_out", 8'h05, pcOut & pcOe);
    readChk("c_pin", REG_C_PIN, 8'h35);
    readChk("c_lat", REG_C_LAT, 8'hA5);
    regWrite(REG_C_DIR, 8'h00);
    settle();
    chk("pc_out_all", 8'hA5, pcOut & pcOe);
    // fourth port mirror image
    pullD <= 8'hC3;
    regWrite(REG_D_LAT, 8'h3C);
    regWrite(REG_D_DIR, 8'h0F);
    settle();
    chk("pd_oe", 8'hF0, pdOe);
    chk("pd_out", 8'h30, pdOut & pdOe);
    readChk("d_pin", REG_D_PIN, 8'h33);
    readChk("d_lat", REG_D_LAT, 8'h3C);
    // one override at a time with both ports configured as inputs
    regWrite(REG_C_DIR, 8'hFF);
    regWrite(REG_D_DIR, 8'hFF);
    for (int i = 0; i < 12; i++) begin
      pin = (i < 8) ? i : (i == 8) ? 1 : i - 4;
      for (int k = 0; k < 12; k++) ovr[k] <= '{en: (k == i), oe: (k == i), out: (k == i)};
      capcompRouting <= (i == 8);
      settle();
      if (i < 9) begin
        chk("pc_ovr_oe", 8'h01 << pin, pcOe);
        chk("pc_ovr_out", 8'h01 << pin, pcOut & pcOe);
      end else begin
        chk("pd_ovr_oe", 8'h01 << pin, pdOe);
        chk("pd_ovr_out", 8'h01 << pin, pdOut & pdOe);
      end
    end
    readChk("c_dir_ovr", REG_C_DIR, 8'hFF);
    // routed capture input follows pad one, forced to input over an output dir
    pullC <= 8'h02;
    for (int k = 0; k < 12; k++) ovr[k] <= '{en: (k == 8), oe: 1'b0, out: 1'b0};
    capcompRouting <= 1'b1;
    regWrite(REG_C_DIR, 8'h00);
    settle();
    chk("pc_ovr_in", 8'hFD, pcOe);
    chk("second_capture_compare_unit_in", 8'h01, {7'h00, ccp2InC});
    readChk("c_dir_kept", REG_C_DIR, 8'h00);
    ovr[8] <= '0;
    // slave mode drives all fourth-port pins from the slave data
    slaveDrive <= 1'b1;
    slaveData  <= 8'h96;
    regWrite(REG_E_CTL, 8'h17);
    settle();
    chk("slave_on", 8'h01, {7'h00, slaveActive});
    chk("slave_data", 8'h96, pdOut & pdOe);
    chk("slave_oe", 8'hFF, pdOe);
    regWrite(REG_PWM_CTL, 8'hCC);
    settle();
    chk("slave_blocked", 8'h00, {7'h00, slaveActive});
    readChk("e_ctl_kept", REG_E_CTL, 8'h17);
    // single output pwm leaves slave mode alone
    regWrite(REG_PWM_CTL, 8'h0C);
    settle();
    chk("slave_single", 8'h01, {7'h00, slaveActive});
    @(posedge mclk);
    slaveOverflow <= 1'b1;
    @(posedge mclk);
    slaveOverflow <= 1'b0;
    readChk("e_ovf_set", REG_E_CTL, 8'h37);
    regWrite(REG_E_CTL, 8'h07);
    readChk("e_ovf_clr", REG_E_CTL, 8'h07);
    settle();
    chk("slave_off", 8'h00, {7'h00, slaveActive});
    stop_test();
  end
endmodule : test_dual_byte_gpio_ports
